/* logic/sinc_fir_decimation_filter.sv */
// Purpose: Sinc plus four-substage FIR decimator with path, rate and phase selection.
// Assumes: Modulator bit and configuration come from logic on clk; high-pass is downstream.
// Notes: One shared multiplier serves all substages, lowest substage first.
`timescale 1ns/1ns
module sinc_fir_decimation_filter #(
    parameter int DW = filter_pkg::DW,
    parameter int AW = filter_pkg::AW
) (
    input  wire logic                  clk,
    input  wire logic                  srst,
    input  wire logic                  mod_bit,
    input  wire filter_pkg::filt_cfg_t cfg,
    output logic                       mod_tick,
    output filter_pkg::sample_t        sample_out,
    output logic                       sample_valid
);
    localparam int NS = filter_pkg::FIR_STAGES;
    localparam int NT = filter_pkg::MAX_TAPS;
    localparam logic signed [AW-1:0] SAT_HI = {{(AW-DW+1){1'b0}}, {(DW-1){1'b1}}};
    localparam logic signed [AW-1:0] SAT_LO = ~SAT_HI;

    filter_pkg::filt_cfg_t      cfg_q;
    logic                       restart_q;
    logic [1:0]                 div_q;
    logic [2:0]                 rate_eff;
    logic [2:0]                 log2_n;
    logic                       sinc_valid;
    logic signed [DW-1:0]       sinc_word;
    logic signed [DW-1:0]       line_q [NS][NT];
    logic [NS-1:0]              pend_q;
    logic [2:0]                 ph_q   [NS];
    logic [6:0]                 idx_q  [NS];
    logic signed [AW-1:0]       acc_q  [NS];
    logic [1:0]                 sel;
    logic                       busy;
    logic                       last;
    logic signed [DW-1:0]       tap;
    logic signed [filter_pkg::CW-1:0] cf;
    logic signed [AW-1:0]       mac;
    logic signed [AW-1:0]       shr;
    logic signed [DW-1:0]       fir_word;
    logic [NS-1:0]              push;
    logic signed [DW-1:0]       push_data [NS];

    // Configuration is held locally; any change restarts the filter memory cleanly.
    always_ff @(posedge clk) begin
        if (srst) begin
            cfg_q     <= '0; // RULE_17
            restart_q <= 1'b1;
        end else begin
            cfg_q     <= cfg; // RULE_16
            restart_q <= (cfg != cfg_q);
        end
    end

    // Codes above 100 are clamped, so the ratio never falls below eight.
    always_comb begin
        rate_eff = (cfg_q.rate > filter_pkg::RATE_MAX) ? filter_pkg::RATE_MAX : cfg_q.rate;
        log2_n   = 3'(filter_pkg::LOG2_N_MAX) - rate_eff; // RULE_05 RULE_06 RULE_12
    end

    // Modulator rate strobe, one clock in four.
    always_ff @(posedge clk) begin
        if (srst) begin
            div_q    <= '0;
            mod_tick <= 1'b0;
        end else begin
            div_q    <= div_q + 2'h1;
            mod_tick <= (div_q == 2'(filter_pkg::MOD_DIV - 1)); // RULE_04
        end
    end

    sinc5_decimator u_sinc (
        .clk        (clk),
        .srst       (srst),
        .restart    (restart_q),
        .tick       (mod_tick),
        .bit_in     (mod_bit),
        .log2_n     (log2_n),
        .word_valid (sinc_valid),
        .word       (sinc_word)
    );

    // Shared MAC: lowest pending substage wins, so short jobs preempt long ones.
    always_comb begin
        sel = 2'h0;
        for (int s = NS - 1; s >= 0; s--) begin
            if (pend_q[s]) sel = 2'(s); // RULE_07
        end
        busy = |pend_q;
        tap  = line_q[sel][idx_q[sel]];
        cf   = filter_pkg::coef(int'(sel), cfg_q.phase, int'(idx_q[sel])); // RULE_08 RULE_16
        mac  = acc_q[sel] + AW'(tap) * AW'(cf); // RULE_18
        last = busy && (idx_q[sel] == 7'(filter_pkg::TAPS[sel] - 1));
        shr  = (mac + (AW'(1) <<< (filter_pkg::SCALE_SH[sel] - 1)))
             >>> filter_pkg::SCALE_SH[sel]; // RULE_09 RULE_10 RULE_11
        if (shr > SAT_HI) begin
            fir_word = SAT_HI[DW-1:0];
        end else if (shr < SAT_LO) begin
            fir_word = SAT_LO[DW-1:0];
        end else begin
            fir_word = shr[DW-1:0];
        end
        push[0]      = sinc_valid && cfg_q.path[1];
        push_data[0] = sinc_word;
        for (int s = 1; s < NS; s++) begin
            push[s]      = last && (sel == 2'(s - 1));
            push_data[s] = fir_word;
        end
    end

    // Delay lines shift in new samples, newest at tap zero.
    always_ff @(posedge clk) begin
        if (srst || restart_q) begin
            line_q <= '{default: '{default: '0}};
        end else begin
            for (int s = 0; s < NS; s++) begin
                if (push[s]) begin
                    for (int j = NT - 1; j > 0; j--) begin
                        if (j < filter_pkg::TAPS[s]) line_q[s][j] <= line_q[s][j-1];
                    end
                    line_q[s][0] <= push_data[s];
                end
            end
        end
    end

    // Job state; a new job set in the finishing cycle wins over the clear.
    always_ff @(posedge clk) begin
        if (srst || restart_q) begin
            pend_q <= '0;
            ph_q   <= '{default: '0};
            idx_q  <= '{default: '0};
            acc_q  <= '{default: '0};
        end else begin
            for (int s = 0; s < NS; s++) begin
                if (busy && sel == 2'(s)) begin
                    acc_q[s] <= last ? '0 : mac;
                    idx_q[s] <= last ? '0 : idx_q[s] + 7'h01;
                    if (last) pend_q[s] <= 1'b0;
                end
                if (push[s]) begin
                    if (ph_q[s] == 3'(filter_pkg::DEC[s] - 1)) begin
                        ph_q[s]   <= '0;
                        pend_q[s] <= 1'b1; // RULE_07
                    end else begin
                        ph_q[s] <= ph_q[s] + 3'h1;
                    end
                end
            end
        end
    end

    // Output selection; reserved path stays silent.
    always_ff @(posedge clk) begin
        if (srst) begin
            sample_out   <= '0;
            sample_valid <= 1'b0;
        end else begin
            sample_valid <= 1'b0;
            if (cfg_q.path == filter_pkg::PATH_SINC && sinc_valid) begin // RULE_02
                sample_valid      <= 1'b1;
                sample_out.data     <= sinc_word;
                sample_out.from_fir <= 1'b0;
                sample_out.hpf_next <= 1'b0;
            end else if (cfg_q.path[1] && last && sel == 2'(NS - 1) && !restart_q) begin
                sample_valid      <= 1'b1;
                sample_out.data     <= fir_word; // RULE_12 RULE_13
                sample_out.from_fir <= 1'b1;
                sample_out.hpf_next <= (cfg_q.path == filter_pkg::PATH_FIR_HPF); // RULE_01
            end
        end
    end

    // Helper counters that only the checks read.
    logic [9:0] gap_q;
    logic       seen_sinc_q;
    logic [6:0] wcnt_q;
    logic       seen_fir_q;
    logic       fin4;
    assign fin4 = last && sel == 2'(NS - 1);
    always_ff @(posedge clk) begin
        if (srst || restart_q) begin
            gap_q       <= '0;
            seen_sinc_q <= 1'b0;
            wcnt_q      <= '0;
            seen_fir_q  <= 1'b0;
        end else begin
            gap_q <= sinc_valid ? '0 : gap_q + 10'h001;
            if (sinc_valid) seen_sinc_q <= 1'b1;
            if (fin4) begin
                wcnt_q     <= push[0] ? 7'h01 : 7'h00;
                seen_fir_q <= 1'b1;
            end else if (push[0]) begin
                wcnt_q <= wcnt_q + 7'h01;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    chk_tick_period: assert property (mod_tick |=> !mod_tick [*3] ##1 mod_tick) // RULE_04
        else $error("modulator strobe not every fourth clock");
    chk_sinc_gap_ratio: assert property (sinc_valid && seen_sinc_q && !restart_q // RULE_05
        |-> gap_q == 10'((filter_pkg::MOD_DIV << log2_n) - 1))
        else $error("sinc word spacing differs from four times the ratio");
    chk_rate_code_eight: assert property (cfg_q.rate == 3'h4 |-> log2_n == 3'h3) // RULE_06
        else $error("rate code 100 does not select ratio eight");
    chk_fir_total_decim: assert property (fin4 && seen_fir_q && cfg_q.path[1] // RULE_12
        |-> wcnt_q == 7'(filter_pkg::FIR_DEC_TOTAL))
        else $error("FIR output not once per 32 sinc words");
    chk_stage1_served: assert property ($rose(pend_q[0]) |-> ##[1:11] !pend_q[0]) // RULE_07
        else $error("first substage job not finished in its tap count");
    chk_phase_coef_sel: assert property (busy && sel == 2'h2 && idx_q[2] == 7'h02 // RULE_08
        |-> cf == (cfg_q.phase ? filter_pkg::S3_MIN[2] : filter_pkg::S3_LIN[2]))
        else $error("third substage coefficient ignores phase select");
    chk_reserved_quiet: assert property (cfg_q.path == filter_pkg::PATH_RSVD // RULE_02
        |=> !sample_valid)
        else $error("output produced on reserved path");
    chk_hpf_flag_path: assert property (sample_valid // RULE_01
        |-> sample_out.hpf_next == ($past(cfg_q.path) == filter_pkg::PATH_FIR_HPF))
        else $error("high-pass flag disagrees with path select");
    chk_sinc_source: assert property (sample_valid && $past(cfg_q.path) == 2'h1 // RULE_02
        |-> !sample_out.from_fir)
        else $error("sinc path delivered FIR data");

    cov_sinc_out: cover property (sample_valid && !sample_out.from_fir);
    cov_fir_linear: cover property (sample_valid && sample_out.from_fir && !cfg_q.phase);
    cov_fir_minimum: cover property (sample_valid && sample_out.from_fir && cfg_q.phase);
    cov_fir_hpf: cover property (sample_valid && sample_out.hpf_next);
endmodule // sinc_fir_decimation_filter

/* logic/filter_pkg.sv */
// Purpose: Shared constants, types and coefficient tables for the sinc and FIR decimator.
// Assumes: Data words are signed with FRAC fractional bits, full scale is +/-1.0.
// Notes: Linear sets are stored as half tables and mirrored about their centre tap.
// Functional notes
// RULE_01: Path 11 gives sinc, FIR, then high-pass.
// RULE_02: Path 00 reserved, 01 sinc, 10 sinc+FIR.
// RULE_03: Sinc is fifth power of N-sum over N.
// RULE_04: One modulator bit every four clocks.
// RULE_05: Rate codes 000..011 give N 128..16.
// RULE_06: Rate code 100 gives sinc N of 8.
// RULE_07: Four FIR substages decimating 2,2,4,2 = 32.
// RULE_08: Substages three, four have two phase sets.
// RULE_09: Substage one: 11 half-band taps over 512.
// RULE_10: Substage two: 15 half-band taps over 2^23.
// RULE_11: Substages three, four: 52, 110 taps over 2^27.
// RULE_12: FIR path overall decimation 4096 down to 256.
// RULE_13: Pass band flat to 0.375 of rate.
// RULE_14: Linear phase gives constant, longer group delay.
// RULE_15: Minimum phase gives shorter, frequency-varying delay.
// RULE_16: One phase bit steers coefficient choice.
// RULE_17: Phase 0 linear, 1 minimum, reset linear.
// RULE_18: Accumulators wide enough to never overflow.
package filter_pkg;
    localparam int DW         = 32;
    localparam int FRAC       = 30;
    localparam int CW         = 28;
    localparam int AW         = 72;
    localparam int MOD_DIV    = 4;
    localparam int SINC_ORDER = 5;
    localparam int LOG2_N_MAX = 7;
    localparam int SINC_W     = 37;
    localparam logic [1:0] PATH_RSVD    = 2'h0;
    localparam logic [1:0] PATH_SINC    = 2'h1;
    localparam logic [1:0] PATH_FIR     = 2'h2;
    localparam logic [1:0] PATH_FIR_HPF = 2'h3;
    localparam logic [2:0] RATE_MAX     = 3'h4;
    localparam logic       PHASE_LIN    = 1'b0;
    localparam logic       PHASE_MIN    = 1'b1;
    localparam int FIR_STAGES    = 4;
    localparam int MAX_TAPS      = 110;
    localparam int FIR_DEC_TOTAL = 32;
    localparam int TAPS     [4] = '{11, 15, 52, 110};
    localparam int DEC      [4] = '{2, 2, 4, 2};
    localparam int SCALE_SH [4] = '{9, 23, 27, 27};
    localparam int CENTER   [4] = '{5, 7, 25, 54};

    typedef struct packed {
        logic [1:0] path;
        logic [2:0] rate;
        logic       phase;
    } filt_cfg_t;

    typedef struct packed {
        logic signed [DW-1:0] data;
        logic                 from_fir;
        logic                 hpf_next;
    } sample_t;

    // Substage one and two half tables, centre tap last.
    localparam logic signed [CW-1:0] S1_LIN [6] = '{3, 0, -25, 0, 150, 256}; // RULE_09
    localparam logic signed [CW-1:0] S2_LIN [8] = '{-10944, 0, 103807, 0, -507903, 0, // RULE_10
        2512192, 4194304};
    // Substage three sets.
    localparam logic signed [CW-1:0] S3_LIN [26] = '{0, 0, -73, -874, -4648, -16147, // RULE_11
        -41280, -80934, -120064, -118690, -18203, 224751, 580196, 893263, 891396, 293598,
        -987253, -2635779, -3860322, -3572512, -822573, 4669054, 12153698, 19911100,
        25779390, 27966862};
    localparam logic signed [CW-1:0] S3_MIN [52] = '{819, 8211, 44880, 174712, 536821,
        1372637, 3012996, 5788605, 9852286, 14957445, 20301435, 24569234, 26260385,
        24247577, 18356231, 9668991, 327749, -7171917, -10926627, -10379094, -6505618,
        -1333678, 2972773, 5006366, 4566808, 2505652, 126331, -1496514, -1933830,
        -1410695, -502731, 245330, 565174, 492084, 231656, -9196, -125456, -122207,
        -61813, -4445, 22484, 22245, 10775, 940, -2953, -2599, -1052, -43, 214, 132, 33, 0};
    // Substage four sets.
    localparam logic signed [CW-1:0] S4_LIN [55] = '{-132, -432, -75, 2481, 6692, 7419,
        -266, -10663, -8280, 10620, 22008, 348, -34123, -25549, 33460, 61387, -7546,
        -94192, -50629, 101135, 134826, -56626, -220104, -56082, 263758, 231231, -215231,
        -430178, 34715, 580424, 283878, -588382, -693209, 366118, 1084786, 132893,
        -1300087, -878642, 1162189, 1741565, -522533, -2490395, -688945, 2811738,
        2425494, -2338095, -4511116, 641555, 6661730, 2950811, -8538057, -10537298,
        9818477, 41426374, 56835776};
    localparam logic signed [CW-1:0] S4_MIN [110] = '{11767, 133882, 769961, 2940447,
        8262605, 17902757, 30428735, 40215494, 39260213, 23325925, -1757787, -21028126,
        -21293602, -3886901, 14396783, 16314388, 1518875, -12979500, -11506007, 2769794,
        12195551, 6103823, -6709466, -9882714, -353347, 8629331, 5597927, -4389168,
        -7594158, -428064, 6566217, 4024593, -3679749, -5572954, 332589, 5136333,
        2351253, -3357202, -3767666, 1087392, 3847821, 919792, -2918303, -2193542,
        1493873, 2595051, -79991, -2260106, -963855, 1482337, 1480417, -586408,
        -1497356, -168417, 1166800, 644405, -675082, -806095, 211391, 740896, 141976,
        -527673, -327618, 278227, 363809, -70646, -304819, -63159, 205798, 124363,
        -107173, -131357, 31104, 107182, 15644, -71728, -36319, 38331, 38783, -13557,
        -31453, -1230, 20983, 7729, -11463, -8791, 4659, 7126, -732, -4687, -976, 2551,
        1339, -1103, -1085, 314, 681, 16, -349, -96, 144, 78, -46, -42, 9, 16, 0, -4, 0, 0};

    // Tap lookup; linear sets mirror about the centre, past the mirror they read zero.
    function automatic logic signed [CW-1:0] coef(input int s, input logic ph, input int i);
        int m;
        m = (i <= CENTER[s]) ? i : 2 * CENTER[s] - i;
        coef = '0;
        if (m >= 0) begin
            case (s)
                0:       coef = S1_LIN[m];
                1:       coef = S2_LIN[m];
                2:       coef = (ph == PHASE_MIN) ? S3_MIN[i] : S3_LIN[m]; // RULE_14
                default: coef = (ph == PHASE_MIN) ? S4_MIN[i] : S4_LIN[m]; // RULE_15
            endcase
        end
    endfunction
endpackage

/* logic/sinc5_decimator.sv */
// Purpose: Fifth-order sinc decimator for a one-bit stream with ratio 2^log2_n.
// Assumes: tick marks one modulator bit; log2_n stays in 3..7 between restarts.
// Notes: Output is normalised to full scale +/-1.0 with FRAC fractional bits.
`timescale 1ns/1ns
module sinc5_decimator #(
    parameter int W    = filter_pkg::SINC_W,
    parameter int DW   = filter_pkg::DW,
    parameter int KMAX = filter_pkg::LOG2_N_MAX
) (
    input  wire logic                 clk,
    input  wire logic                 srst,
    input  wire logic                 restart,
    input  wire logic                 tick,
    input  wire logic                 bit_in,
    input  wire logic [2:0]           log2_n,
    output logic                      word_valid,
    output logic signed [DW-1:0]      word
);
    localparam int ORD = filter_pkg::SINC_ORDER;
    localparam int PRE = ORD * KMAX - filter_pkg::FRAC;
    localparam int SW  = 2 * W;

    logic signed [W-1:0]  integ_q [ORD];
    logic signed [W-1:0]  dly_q   [ORD];
    logic signed [W-1:0]  comb_v  [ORD];
    logic [KMAX-1:0]      cnt_q;
    logic                 dump;
    logic signed [SW-1:0] scaled;

    // Comb chain, each stage differencing against its value at the previous dump.
    always_comb begin
        comb_v[0] = integ_q[ORD-1] - dly_q[0]; // RULE_03
        for (int j = 1; j < ORD; j++) begin
            comb_v[j] = comb_v[j-1] - dly_q[j];
        end
        dump   = tick && (cnt_q == KMAX'((1 << log2_n) - 1));
        scaled = (SW'(comb_v[ORD-1]) <<< (ORD * KMAX - ORD * int'(log2_n)))
               + (SW'(1) <<< (PRE - 1));
    end

    // Integrators wrap modulo 2^W; the comb difference stays exact because W covers N^5.
    always_ff @(posedge clk) begin
        if (srst || restart) begin
            integ_q <= '{default: '0};
        end else if (tick) begin
            integ_q[0] <= integ_q[0] + (bit_in ? W'(1) : -W'(1)); // RULE_04
            for (int j = 1; j < ORD; j++) begin
                integ_q[j] <= integ_q[j] + integ_q[j-1];
            end
        end
    end

    // Ratio counter stepped on every tick; comb delays loaded at the decimated rate.
    always_ff @(posedge clk) begin
        if (srst || restart) begin
            cnt_q <= '0;
            dly_q <= '{default: '0};
        end else if (tick) begin
            cnt_q <= dump ? '0 : cnt_q + KMAX'(1);
            if (dump) begin
                dly_q[0] <= integ_q[ORD-1];
                for (int j = 1; j < ORD; j++) begin
                    dly_q[j] <= comb_v[j-1];
                end
            end
        end
    end

    // Rounded, normalised output word.
    always_ff @(posedge clk) begin
        if (srst || restart) begin
            word_valid <= 1'b0;
            word       <= '0;
        end else begin
            word_valid <= dump;
            if (dump) begin
                word <= DW'(scaled >>> PRE); // RULE_18
            end
        end
    end

    chk_word_range: assert property (@(posedge clk) disable iff (srst) // RULE_18
        word_valid |-> (word <= (DW'(1) <<< filter_pkg::FRAC))
                    && (word >= -(DW'(1) <<< filter_pkg::FRAC)))
        else $error("sinc word beyond full scale");
endmodule // sinc5_decimator

/* verif/mod_stream_source.sv */
// Purpose: Behavioural source of the one-bit modulator stream for the decimator.
// Assumes: A bit is offered in the cycle where the filter's tick is high.
// Notes: Outside tick cycles the line carries the inverse, so a stale bit never helps.
`timescale 1ns/1ns
module mod_stream_source (
    input  wire logic       clk,
    input  wire logic       mod_tick,
    input  wire logic [1:0] mode,
    output logic            mod_bit
);
    // Starts low so the alternating pattern is defined from the first strobe.
    logic alt_q = 1'b0;

    // Mode 0 gives all ones, 1 all zeros, 2 an alternating stream.
    always @(negedge clk) begin
        logic b;
        b = (mode == 2'h0) ? 1'b1 : ((mode == 2'h1) ? 1'b0 : alt_q);
        if (mod_tick) begin
            mod_bit <= b;
            alt_q   <= ~alt_q;
        end else begin
            mod_bit <= ~b;
        end
    end
endmodule // mod_stream_source

/* verif/test_sinc_fir_decimation_filter.sv */
// Purpose: Self-checking bench for the sinc and FIR decimator.
// Assumes: Bit one means +1.0 full scale, which reads 32'h40000000 in Q2.30.
// Notes: FIR runs use the fastest rate only, to keep the run short.
`timescale 1ns/1ns
module test_sinc_fir_decimation_filter;
    logic                  clk;
    logic                  srst;
    filter_pkg::filt_cfg_t cfg;
    logic [1:0]            mode;
    logic                  mod_bit;
    logic                  mod_tick;
    filter_pkg::sample_t   sample_out;
    logic                  sample_valid;
    int                    miscompares;
    int                    n_tests;
    int                    k_lin;
    int                    k_min;
    longint                d;

    sinc_fir_decimation_filter i_sinc_fir_decimation_filter (
        .clk(clk), .srst(srst), .mod_bit(mod_bit), .cfg(cfg),
        .mod_tick(mod_tick), .sample_out(sample_out), .sample_valid(sample_valid));

    mod_stream_source i_mod_stream_source (
        .clk(clk), .mod_tick(mod_tick), .mode(mode), .mod_bit(mod_bit));

    // Clock at 10 MHz.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Shared compare; every call counts as one test.
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic results;
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Counts falling edges up to and including the next valid, under a bound.
    task automatic wait_valid(input int limit, output int gap);
        gap = 0;
        do begin
            @(negedge clk);
            gap++;
        end while (sample_valid !== 1'b1 && gap < limit);
        if (sample_valid !== 1'b1) begin
            miscompares++;
            $display("mismatch at %0t: no sample within %0d cycles", $time, limit);
        end
    endtask

    // A config change restarts the filter; let the restart land first.
    task automatic set_cfg(input logic [1:0] path, input logic [2:0] rate, input logic ph,
                           input logic [1:0] pat);
        @(negedge clk);
        cfg  <= '{path: path, rate: rate, phase: ph};
        mode <= pat;
        repeat (4) @(negedge clk);
    endtask

    // Reserved path stays silent while the modulator strobe keeps its one-in-four rate.
    task automatic reserved_path;
        int hits;
        int ticks;
        hits  = 0;
        ticks = 0;
        set_cfg(filter_pkg::PATH_RSVD, 3'h4, filter_pkg::PHASE_LIN, 2'h0);
        repeat (2000) begin
            @(negedge clk);
            if (sample_valid !== 1'b0) hits++;
            if (mod_tick === 1'b1) ticks++;
        end
        check(32'(hits), 32'h0, "reserved path output");
        check(32'(ticks), 32'(2000 / filter_pkg::MOD_DIV), "modulator strobe count");
    endtask

    // Sinc only: exact spacing of 4N and the settled value of a known stream.
    task automatic sinc_rate(input logic [2:0] code, input logic [1:0] pat);
        int          n;
        int          gap;
        logic [31:0] exp;
        n   = 128 >> ((code > filter_pkg::RATE_MAX) ? filter_pkg::RATE_MAX : code);
        exp = (pat == 2'h0) ? 32'h40000000 : ((pat == 2'h1) ? 32'hC0000000 : 32'h0);
        set_cfg(filter_pkg::PATH_SINC, code, filter_pkg::PHASE_LIN, pat);
        wait_valid(8 * n + 64, gap);
        for (int k = 0; k < 7; k++) begin
            wait_valid(4 * n + 8, gap);
            check(32'(gap), 32'(4 * n), "sinc spacing");
            check({30'h0, sample_out.from_fir, sample_out.hpf_next}, 32'h0,
                  "sinc flags");
        end
        check(sample_out.data, exp, "sinc settled value");
    endtask

    // FIR path on all ones: spacing, flags and the output index that first passes half scale.
    task automatic fir_run(input logic [1:0] path, input logic ph, input int outs,
                           output int k_half);
        int gap;
        k_half = 0;
        set_cfg(path, 3'h4, ph, 2'h0);
        wait_valid(4000, gap);
        for (int k = 1; k <= outs; k++) begin
            wait_valid(1100, gap);
            if (k > 2) check(32'(gap), 32'h400, "fir spacing");
            check({30'h0, sample_out.from_fir, sample_out.hpf_next},
                  {30'h0, 1'b1, path == filter_pkg::PATH_FIR_HPF}, "fir flags");
            if (k_half == 0 && $signed(sample_out.data) > 32'sh20000000) k_half = k;
        end
    endtask

    // Main sequence.
    initial begin
        cfg         = '0;
        mode        = 2'h0;
        srst        = 1'b1;
        miscompares = 0;
        n_tests     = 0;
        repeat (2) @(negedge clk);
        srst <= 1'b0;
        reserved_path();
        // Code 101 is included to see that codes above 100 clamp to a ratio of eight.
        for (int c = 0; c < 6; c++) begin
            sinc_rate(3'(c), 2'(c % 3));
        end
        fir_run(filter_pkg::PATH_FIR_HPF, filter_pkg::PHASE_LIN, 60, k_lin);
        d = longint'($signed(sample_out.data)) - 64'sd1073741824;
        check({31'h0, d <= 1048576 && d >= -1048576}, 32'h1, "fir dc gain");
        fir_run(filter_pkg::PATH_FIR, filter_pkg::PHASE_MIN, 16, k_min);
        check({31'h0, k_min > 0 && k_min < k_lin}, 32'h1, "phase delay order");
        results();
    end

    // Watchdog, about a tenth past the expected run of some 90,000 clocks.
    initial begin
        #10000000;
        miscompares++;
        $display("mismatch at %0t: watchdog expired", $time);
        results();
    end
endmodule // test_sinc_fir_decimation_filter
